/* File: src/syp_pkg.sv */
// Behaviour
// - Port works only while port_enable set
// - Master: buffer write starts eight-bit exchange
// - Master, output off: keep receiving bytes
// - clock_idle_polarity sets serial clock idle level
// - Master rates: osc/4, /16, /64, timer/2
// - clock_edge_select: data valid before first edge
// - Bytes shift most significant bit first
// - Shift on one edge, latch on other
// - Slave: external clock, flag on last bit
// - Slave keeps shifting during sleep, then wakes
// - Select mode: low select drives, high releases
// - Port reset forces bit counter to zero
// - Master freezes in sleep, resumes after
// - Device reset disables port, aborts transfer
// - Standard modes map onto polarity/edge bits
// - Master: input_sample_phase picks middle or end sampling
// - Received byte sets full and interrupt flags
// - Busy write ignored, sets write_collision_flag
// - Slave overflow flag, new byte discarded
package syp_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices as printed; the byte address is four times the index.
    localparam logic [7:0] IDX_GLOBAL_INT   = 8'h0b;  // Global interrupt control.
    localparam logic [7:0] IDX_PERIPH_FLAGS = 8'h0c;  // Peripheral interrupt flags one.
    localparam logic [7:0] IDX_SHIFT_BUF    = 8'h13;  // Serial shift buffer.
    localparam logic [7:0] IDX_PORT_CTRL    = 8'h14;  // Serial port control.
    localparam logic [7:0] IDX_PORT_A_DIR   = 8'h85;  // Port A direction.
    localparam logic [7:0] IDX_PORT_C_DIR   = 8'h87;  // Port C direction.
    localparam logic [7:0] IDX_PERIPH_ENS   = 8'h8c;  // Peripheral interrupt enables one.
    localparam logic [7:0] IDX_PORT_STAT    = 8'h94;  // Serial port status.

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int CTL_WRITE_COLLISION_FLAG   = 7;  // Write collision flag.
    localparam int CTL_OV     = 6;  // Receive overflow flag.
    localparam int CTL_EN     = 5;  // Port enable.
    localparam int CTL_CKP    = 4;  // Clock idle polarity.
    localparam int STAT_SMP   = 7;  // Input sample phase.
    localparam int STAT_CKE   = 6;  // Clock edge select.
    localparam int STAT_BF    = 0;  // Buffer full flag.
    localparam int PIR_PORTIF = 3;  // Port interrupt flag / enable position.
    localparam int PORT_C_DIRECTION_SDO  = 4;  // Data out direction bit.
    localparam int PORT_C_DIRECTION_SCK  = 6;  // Clock direction bit.

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [7:0] RST_ZERO = 8'h00;  // Control, status, flags, enables.
    localparam logic [7:0] RST_DIR  = 8'hff;  // Direction registers: all inputs.

    ////////////////////////////////////////////////////////////////////////////////
    // Mode select encodings.
    localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
    localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
    localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
    localparam logic [3:0] MODE_MASTER_TMR   = 4'h3;
    localparam logic [3:0] MODE_SLAVE_SEL    = 4'h4;
    localparam logic [3:0] MODE_SLAVE_NOSEL  = 4'h5;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing: half periods of the serial clock in oscillator cycles.
    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;  // Sixteen clock edges per byte.

    // Transfer engine states, Gray coded.
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_RUN  = 1'b1
    } syp_state_t;

    // Serial pin outputs and enables carried together.
    typedef struct packed {
        logic sck_o;   // Serial clock level when driven.
        logic sck_oe;  // Serial clock drive enable.
        logic sdo_o;   // Serial data out level.
        logic sdo_oe;  // Serial data out drive enable.
    } syp_pins_t;

endpackage : syp_pkg

/* File: src/syp_port.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ns
module syp_port
    import syp_pkg::*;
(
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device context.
    input  wire logic        sleep_mode,
    input  wire logic        timer_tick,
    output logic             wake_request,
    // Serial pins.
    input  wire logic        sck_i,
    input  wire logic        serial_data_in,
    input  wire logic        select_n,
    output syp_pins_t        pins
);

    ////////////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0] ctl_reg,    ctl_next;     // Serial port control.
    logic [1:0] cfg_reg,    cfg_next;     // Sample phase and edge select.
    logic       bf_reg,     bf_next;      // Buffer full flag.
    logic [7:0] buf_reg,    buf_next;     // Receive buffer.
    logic [7:0] pir_reg,    pir_next;     // Peripheral flags.
    logic [7:0] pie_reg,    pie_next;     // Peripheral enables.
    logic [7:0] intc_reg,   intc_next;    // Global interrupt control.
    logic [7:0] port_a_direction_reg,  port_a_direction_next;   // Port A direction.
    logic [7:0] port_c_direction_reg,  port_c_direction_next;   // Port C direction.
    logic [31:0] prdata_reg, prdata_next; // Read data.
    logic       pready_reg, pready_next;  // Access completion.
    logic       perr_reg,   perr_next;    // Unmapped access.
    logic       wake_reg,   wake_next;    // Wake request level.

    // Engine state.
    syp_state_t state_reg, state_next;     // Master transfer state.
    logic [4:0] tick_reg,   tick_next;     // Clock edges seen in this byte.
    logic [5:0] div_reg,    div_next;      // Rate divider.
    logic [7:0] tx_reg,     tx_next;       // Transmit half of the shifter.
    logic [7:0] rx_reg,     rx_next;       // Receive half of the shifter.
    logic       sckp_reg,   sckp_next;     // Previous clock pin level.
    syp_pins_t  pins_reg,   pins_next;     // Registered pin drive.

    ////////////////////////////////////////////////////////////////////////////////
    // Decode of the control bits.
    logic       enabled;
    logic       master;
    logic       sel_mode;
    logic       sel_high;
    logic       cke;
    logic       input_sample_phase;
    logic       access;
    logic       wr;
    logic       rd;
    logic [7:0] idx;
    logic       idx_ok;

    assign enabled  = ctl_reg[CTL_EN];
    assign master   = (ctl_reg[3:0] <= MODE_MASTER_TMR);
    assign sel_mode = (ctl_reg[3:0] == MODE_SLAVE_SEL);
    // Only the select-controlled slave looks at the select pin.
    assign sel_high = sel_mode && select_n;
    assign cke      = cfg_reg[0];
    assign input_sample_phase      = cfg_reg[1];
    // The access phase completes on the second cycle, when pready is high.
    assign access   = psel && penable && pready_reg;
    assign wr       = access && pwrite;
    assign rd       = access && !pwrite;
    assign idx      = paddr[9:2];
    assign idx_ok   = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);

    ////////////////////////////////////////////////////////////////////////////////
    // Tick generation: one pulse per serial clock edge.
    logic       half_hit;   // Master half period elapsed.
    logic [5:0] half_len;   // Selected half period.
    logic       tick;       // Edge event for the engine.
    logic       slave_edge; // External clock edge seen.

    always_comb begin
        case (ctl_reg[3:0])
            MODE_MASTER_DIV4:  half_len = HALF_DIV4;
            MODE_MASTER_DIV16: half_len = HALF_DIV16;
            default:           half_len = HALF_DIV64;
        endcase
    end

    // Timer mode gives one half period per timer pulse, so the bit rate is the timer rate over two.
    assign half_hit   = (ctl_reg[3:0] == MODE_MASTER_TMR) ? timer_tick
                      : (div_reg == half_len - 6'h01);
    // Sleep stops the master clock; counters simply hold their state.
    assign tick       = master ? (state_reg == ST_RUN && !sleep_mode && half_hit)
                               : slave_edge;
    // The slave engine runs in sleep too, since it is paced only by the pin.
    assign slave_edge = enabled && !master && !sel_high && (sck_i != sckp_reg);

    ////////////////////////////////////////////////////////////////////////////////
    // Bit position helpers for the edge count after this tick.
    logic [4:0] t_new;      // Edge count including this tick.
    logic [4:0] out_pos;    // Edge index relative to the first output change.
    logic [4:0] smp_off;    // Edge index of the first sample.
    logic [4:0] smp_pos;    // Edge index relative to the first sample.
    logic [4:0] end_t;      // Edge count that closes the byte.
    logic       out_now;    // This tick changes the data output.
    logic       smp_now;    // This tick samples the data input.
    logic       last_smp;   // This sample completes the byte.

    always_comb begin
        t_new = tick_reg + 5'h01;
        // Edge select 1 puts bit 7 out before the first edge, so changes fall on even counts.
        out_pos = cke ? t_new : t_new - 5'h01;
        // Sampling on the opposite edge; the late phase waits until the end of the bit time.
        smp_off = 5'h01 + {4'h0, !cke} + {4'h0, input_sample_phase && master};
        smp_pos = t_new - smp_off;
        out_now = (out_pos[0] == 1'b0) && (out_pos < EDGES_PER_BYTE) && (out_pos != 5'h00);
        smp_now = (t_new >= smp_off) && (smp_pos[0] == 1'b0) && (smp_pos[4:1] < 4'h8);
        last_smp = smp_now && (smp_pos[4:1] == 4'h7);
        end_t   = (smp_off + 5'h0e > EDGES_PER_BYTE) ? smp_off + 5'h0e : EDGES_PER_BYTE;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Engine next state: shifting, completion and the buffer hand-over.
    logic busy;        // A transfer is under way.
    logic buf_wr;      // Software writes the shift buffer.
    logic start;       // A master byte starts now.
    logic monitor;     // Master with data out disabled keeps receiving.
    logic done;        // Receive byte complete.
    logic byte_end;    // Edge count reaches the byte end.

    assign busy     = master ? (state_reg == ST_RUN) : (tick_reg != 5'h00);
    // Only an aligned, mapped buffer address may start or load a byte.
    assign buf_wr   = wr && idx_ok && (idx == IDX_SHIFT_BUF);
    assign monitor  = master && port_c_direction_reg[PORT_C_DIRECTION_SDO];
    // A buffer write while idle starts the byte at once; a monitoring master restarts itself.
    assign start    = enabled && master && !busy && (buf_wr || monitor) && !sleep_mode;
    assign done     = tick && last_smp;
    assign byte_end = tick && (t_new == end_t);

    always_comb begin
        state_next = state_reg;
        tick_next  = tick_reg;
        div_next   = div_reg;
        tx_next    = tx_reg;
        rx_next    = rx_reg;
        sckp_next  = sck_i;
        pins_next  = pins_reg;
        // Master divider counts only while running and awake.
        if (state_reg == ST_RUN && !sleep_mode) begin
            div_next = half_hit ? 6'h00 : div_reg + 6'h01;
        end
        if (start) begin
            state_next      = ST_RUN;
            tick_next       = 5'h00;
            div_next        = 6'h00;
            tx_next         = buf_wr ? pwdata[7:0] : tx_reg;
            // Edge select 1 shows bit 7 before the first edge.
            pins_next.sdo_o = buf_wr ? pwdata[7] : tx_reg[7];
        end else if (!master && !busy && buf_wr) begin
            // Slave loads the byte it will answer with.
            tx_next         = pwdata[7:0];
            pins_next.sdo_o = pwdata[7];
        end else if (tick) begin
            tick_next = t_new;
            if (master && t_new <= EDGES_PER_BYTE) begin
                pins_next.sck_o = !pins_reg.sck_o;
            end
            if (out_now) begin
                // Next bit, most significant first.
                pins_next.sdo_o = tx_reg[3'h7 - out_pos[3:1]];
            end else if (!cke && t_new == 5'h01) begin
                pins_next.sdo_o = tx_reg[7];
            end
            if (smp_now) begin
                rx_next = {rx_reg[6:0], serial_data_in};
            end
            if (byte_end) begin
                tick_next  = 5'h00;
                state_next = ST_IDLE;
            end
        end
        // Idle clock level follows the polarity bit between bytes.
        if (master && state_next == ST_IDLE) begin
            pins_next.sck_o = ctl_reg[CTL_CKP];
        end
        // Select high or disable is a port reset: the edge count returns to zero.
        if (!enabled || sel_high) begin
            state_next = ST_IDLE;
            tick_next  = 5'h00;
            div_next   = 6'h00;
        end
        // Pin drives follow enable, mode, direction bits and the select pin.
        pins_next.sck_oe = enabled && master && !port_c_direction_reg[PORT_C_DIRECTION_SCK];
        pins_next.sdo_oe = enabled && !port_c_direction_reg[PORT_C_DIRECTION_SDO] && !sel_high;
        if (!enabled) begin
            pins_next.sck_o = ctl_reg[CTL_CKP];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        // Device reset aborts the byte and leaves the pins released.
        if (!presetn) begin
            state_reg <= ST_IDLE;
            tick_reg  <= 5'h00;
            div_reg   <= 6'h00;
            tx_reg    <= 8'h00;
            rx_reg    <= 8'h00;
            sckp_reg  <= 1'b0;
            pins_reg  <= '0;
        end else begin
            state_reg <= state_next;
            tick_reg  <= tick_next;
            div_reg   <= div_next;
            tx_reg    <= tx_next;
            rx_reg    <= rx_next;
            sckp_reg  <= sckp_next;
            pins_reg  <= pins_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register file next values, including flag side effects.
    logic [7:0] rd_val;   // Read mux output.
    logic       overrun;  // Slave byte arrives over an unread buffer.
    logic [7:0] rx_full;  // Completed byte including the final bit.

    assign rx_full = {rx_reg[6:0], serial_data_in};
    // Master never overflows: overflow is gated to the slave, so a monitoring master overwrites the buffer.
    assign overrun = done && !master && bf_reg;

    always_comb begin
        case (idx)
            IDX_GLOBAL_INT:   rd_val = intc_reg;
            IDX_PERIPH_FLAGS: rd_val = pir_reg;
            IDX_SHIFT_BUF:    rd_val = buf_reg;
            IDX_PORT_CTRL:    rd_val = ctl_reg;
            IDX_PORT_A_DIR:   rd_val = port_a_direction_reg;
            IDX_PORT_C_DIR:   rd_val = port_c_direction_reg;
            IDX_PERIPH_ENS:   rd_val = pie_reg;
            IDX_PORT_STAT:    rd_val = {cfg_reg[1], cfg_reg[0], 5'h00, bf_reg};
            default:          rd_val = 8'h00;
        endcase
    end

    always_comb begin
        logic mapped;
        mapped      = idx_ok && (idx == IDX_GLOBAL_INT || idx == IDX_PERIPH_FLAGS ||
                      idx == IDX_SHIFT_BUF || idx == IDX_PORT_CTRL || idx == IDX_PORT_A_DIR ||
                      idx == IDX_PORT_C_DIR || idx == IDX_PERIPH_ENS || idx == IDX_PORT_STAT);
        ctl_next    = ctl_reg;
        cfg_next    = cfg_reg;
        bf_next     = bf_reg;
        buf_next    = buf_reg;
        pir_next    = pir_reg;
        pie_next    = pie_reg;
        intc_next   = intc_reg;
        port_a_direction_next  = port_a_direction_reg;
        port_c_direction_next  = port_c_direction_reg;
        // Each access completes after one wait cycle.
        pready_next = psel && penable && !pready_reg;
        prdata_next = prdata_reg;
        perr_next   = 1'b0;
        if (psel && penable && !pready_reg) begin
            prdata_next = {24'h000000, (mapped && !pwrite) ? rd_val : 8'h00};
            perr_next   = !mapped;
        end
        // Software writes come first so that hardware sets below win over clears.
        if (wr && mapped) begin
            case (idx)
                IDX_GLOBAL_INT:   intc_next  = pwdata[7:0];
                IDX_PERIPH_FLAGS: pir_next   = pwdata[7:0];
                IDX_PORT_CTRL:    ctl_next   = pwdata[7:0];  // Flags cleared by writing zero.
                IDX_PORT_A_DIR:   port_a_direction_next = pwdata[7:0];
                IDX_PORT_C_DIR:   port_c_direction_next = pwdata[7:0];
                IDX_PERIPH_ENS:   pie_next   = pwdata[7:0];
                IDX_PORT_STAT:    cfg_next   = pwdata[STAT_SMP:STAT_CKE];
                default:          ctl_next   = ctl_reg;
            endcase
        end
        // Reading the buffer empties it.
        if (rd && idx_ok && idx == IDX_SHIFT_BUF) begin
            bf_next = 1'b0;
        end
        // A write during a byte is dropped and flagged.
        if (buf_wr && idx_ok && enabled && busy) begin
            ctl_next[CTL_WRITE_COLLISION_FLAG] = 1'b1;
        end
        if (overrun) begin
            ctl_next[CTL_OV]     = 1'b1;
            pir_next[PIR_PORTIF] = 1'b1;
        end else if (done) begin
            buf_next             = rx_full;
            bf_next              = 1'b1;
            pir_next[PIR_PORTIF] = 1'b1;
        end
        // Flag and enable together ask the device to wake.
        wake_next = pir_next[PIR_PORTIF] && pie_next[PIR_PORTIF];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        // Reset clears control, which disables the port.
        if (!presetn) begin
            ctl_reg    <= RST_ZERO;
            cfg_reg    <= 2'b00;
            bf_reg     <= 1'b0;
            buf_reg    <= RST_ZERO;
            pir_reg    <= RST_ZERO;
            pie_reg    <= RST_ZERO;
            intc_reg   <= RST_ZERO;
            port_a_direction_reg  <= RST_DIR;
            port_c_direction_reg  <= RST_DIR;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            perr_reg   <= 1'b0;
            wake_reg   <= 1'b0;
        end else begin
            ctl_reg    <= ctl_next;
            cfg_reg    <= cfg_next;
            bf_reg     <= bf_next;
            buf_reg    <= buf_next;
            pir_reg    <= pir_next;
            pie_reg    <= pie_next;
            intc_reg   <= intc_next;
            port_a_direction_reg  <= port_a_direction_next;
            port_c_direction_reg  <= port_c_direction_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            perr_reg   <= perr_next;
            wake_reg   <= wake_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops.
    assign prdata       = prdata_reg;
    assign pready       = pready_reg;
    assign pslverr      = perr_reg;
    assign wake_request = wake_reg;
    assign pins         = pins_reg;

endmodule : syp_port

/* File: bench/syp_port_asserts.sv */
`timescale 1ns/1ns
// Watches the bus handshake and the pacing of the driven serial clock.
module syp_port_chk
    import syp_pkg::*;
(
    // Clock, reset and bus.
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Device context and pins.
    input wire logic        sleep_mode,
    input syp_pins_t        pins
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not after one wait");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_zero: assert property (pslverr |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_rdata_width: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_sck_half: assert property (pins.sck_oe && $past(pins.sck_oe) && $changed(pins.sck_o) |=> $stable(pins.sck_o))
        else $error("serial clock half period short");
    a_sleep_freeze: assert property (sleep_mode && $past(sleep_mode) && pins.sck_oe |=> $stable(pins.sck_o))
        else $error("serial clock moved in sleep");
endmodule : syp_port_chk
////////////////////////////////////////
bind syp_port syp_port_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleep_mode(sleep_mode), .pins(pins));

/* File: bench/syp_far_dev.sv */
`timescale 1ns/1ns
// Far-side shifter; it drives on the falling edge and latches on the rising one.
module syp_far_dev (
    // Serial lines.
    input  wire logic       sck,
    input  wire logic       mosi,
    output logic            miso,
    // Byte load and capture.
    input  wire logic       load,
    input  wire logic [7:0] tx,
    output logic      [7:0] rx = 8'h00
);
    logic [7:0] sh_reg = 8'h00;  // Outgoing byte, top bit on the line.
    assign miso = sh_reg[7];
    // Preloading before the first edge keeps data valid early; refill bits toggle so stale data shows.
    always @(negedge sck or posedge load) begin
        if (load) sh_reg <= tx;
        else sh_reg <= {sh_reg[6:0], ~sh_reg[0]};
    end
    // Rising-edge latch, same polarity as the port.
    always @(posedge sck) rx <= {rx[6:0], mosi};
endmodule : syp_far_dev

/* File: bench/syp_port_tb_top.sv */
`timescale 1ns/1ns
// Drives the port over the bus and against the far-side shifter.
module sync_serial_spi_port_tb_top
    import syp_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, sleep_mode, timer_tick, tb_sck, select_n;
    logic        pready, pslverr, wake_request, far_ld, sdo_last;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0]  far_tx, far_rx, tx, ftx, st;
    logic [1:0]  tcnt;
    syp_pins_t   pins;
    logic [32:0] notes[$];  // Expected read answers, oldest first.
    int          n_mismatch, n_checks;
    int          half_cyc [4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 4};
    logic [7:0]  ridx [6] = '{IDX_PERIPH_FLAGS, IDX_PORT_CTRL, IDX_PORT_A_DIR, IDX_PORT_C_DIR, IDX_PERIPH_ENS, IDX_PORT_STAT};
    logic [7:0]  rval [6] = '{RST_ZERO, RST_ZERO, RST_DIR, RST_DIR, RST_ZERO, RST_ZERO};
    wire         miso_w;
    wire         sck_w = pins.sck_oe ? pins.sck_o : tb_sck;
    wire         sdo_w = pins.sdo_oe ? pins.sdo_o : ~sdo_last;  // Released line shows the inverse.
    syp_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sleep_mode(sleep_mode), .timer_tick(timer_tick), .wake_request(wake_request),
        .sck_i(sck_w), .serial_data_in(miso_w), .select_n(select_n), .pins(pins));
    syp_far_dev u_far (.sck(sck_w), .mosi(sdo_w), .miso(miso_w), .load(far_ld), .tx(far_tx), .rx(far_rx));
    always #5 pclk = ~pclk;
    // Timer pulse every fourth cycle paces the timer rate; last driven data bit is kept.
    always @(posedge pclk) begin
        tcnt <= tcnt + 2'h1;
        timer_tick <= (tcnt == 2'h0);
        if (pins.sdo_oe) sdo_last <= pins.sdo_o;
    end
    // Each answered read takes the oldest note.
    always @(posedge pclk) if (psel && penable && pready === 1'b1 && !pwrite) chk("prdata", notes.pop_front(), {pslverr, prdata});
    task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc
    // One bus transfer; the wait is bounded only by the watchdog.
    task automatic xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {2'h0, i, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic rd(input logic [7:0] i, input logic [7:0] e, input logic er = 1'b0);
        notes.push_back({er, 24'h0, e});
        xfer(1'b0, i, 8'h00);
    endtask : rd
    task automatic load_far(input logic [7:0] b);
        far_tx <= b;
        cyc(1);
        far_ld <= 1'b1;
        cyc(1);
        far_ld <= 1'b0;
    endtask : load_far
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        cyc(20000);
        n_mismatch++;
        end_of_test();
    end
    initial begin
        {pclk, presetn, psel, penable, pwrite, sleep_mode, timer_tick, tb_sck, far_ld, sdo_last} = '0;
        {select_n, tcnt, paddr, pwdata, far_tx, n_mismatch, n_checks} = '0;
        select_n = 1'b1;
        void'($urandom(29));
        cyc(5);
        presetn <= 1'b1;
        foreach (ridx[k]) rd(ridx[k], rval[k]);
        rd(8'h20, 8'h00, 1'b1);
        $display("test reset_values done");
        xfer(1'b1, IDX_PORT_C_DIR, 8'haf);
        xfer(1'b1, IDX_PORT_STAT, 8'h40);
        for (int m = 0; m < 4; m++) begin
            tx  = $urandom;
            ftx = $urandom;
            xfer(1'b1, IDX_PORT_CTRL, 8'h00);
            xfer(1'b1, IDX_PORT_CTRL, 8'h20 | m[7:0]);
            // One rate samples at the end of the bit time; the bytes seen must not change.
            st = (m == 2) ? 8'hc0 : 8'h40;
            xfer(1'b1, IDX_PORT_STAT, st);
            load_far(ftx);
            xfer(1'b1, IDX_SHIFT_BUF, tx);
            xfer(1'b1, IDX_SHIFT_BUF, ~tx);
            sleep_mode <= 1'b1;
            cyc(40);
            sleep_mode <= 1'b0;
            cyc(16 * half_cyc[m] + 8);
            rd(IDX_PORT_STAT, st | 8'h01);
            rd(IDX_PORT_CTRL, 8'ha0 | m[7:0]);
            rd(IDX_SHIFT_BUF, ftx);
            rd(IDX_PORT_STAT, st);
            chk("far_rx", {25'h0, tx}, {25'h0, far_rx});
            $display("test master_mode %0d done", m);
        end
        xfer(1'b1, IDX_PORT_CTRL, 8'h04);
        xfer(1'b1, IDX_PORT_CTRL, 8'h24);
        xfer(1'b1, IDX_PORT_C_DIR, 8'hef);
        xfer(1'b1, IDX_PERIPH_ENS, 8'h08);
        xfer(1'b1, IDX_PERIPH_FLAGS, 8'h00);
        // First byte is left unread on purpose so the second byte overflows the buffer.
        for (int b = 0; b < 2; b++) begin
            tx = $urandom;
            if (b == 0) ftx = $urandom;
            xfer(1'b1, IDX_SHIFT_BUF, tx);
            load_far(b == 0 ? ftx : ~ftx);
            select_n   <= 1'b0;
            sleep_mode <= 1'b1;
            repeat (16) begin
                cyc(4);
                tb_sck <= ~tb_sck;
            end
            cyc(4);
            select_n <= 1'b1;
            cyc(2);
            chk("sdo_oe", 33'h0, {32'h0, pins.sdo_oe});
            chk("wake", 33'h1, {32'h0, wake_request});
            sleep_mode <= 1'b0;
            chk("far_rx", {25'h0, tx}, {25'h0, far_rx});
        end
        rd(IDX_PORT_CTRL, 8'h64);
        rd(IDX_SHIFT_BUF, ftx);
        $display("test slave_select done");
        end_of_test();
    end
endmodule : sync_serial_spi_port_tb_top
